/* File: cawd_pkg.sv */
package cawd_pkg;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL_FLAGS = 8'hd8;
    localparam logic [7:0] ADDR_MODE          = 8'hd9;
    localparam logic [7:0] ADDR_COUNTER_LOW   = 8'he9;
    localparam logic [7:0] ADDR_COUNTER_HIGH  = 8'hf9;
    localparam logic [7:0] ADDR_WD_OFFSET     = 8'hcf;
    localparam logic [7:0] ADDR_WD_UPDATE     = 8'hd0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [7:0]  MODE_RESET    = 8'h40;
    localparam logic [15:0] COUNTER_RESET = 16'h0000;
    localparam logic [7:0]  BYTE_RESET    = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_OVF_BIT  = 7;
    localparam int CTRL_RUN_BIT  = 6;
    localparam int CTRL_FIVE_BIT = 5;
    localparam int MODE_IDLE_BIT = 7;
    localparam int MODE_WDE_BIT  = 6;
    localparam int MODE_LOCK_BIT = 5;
    localparam int MODE_TB_LSB   = 1;
    localparam int MODE_OVFI_BIT = 0;
    localparam int NUM_MODULES   = 6;

    // ------------------------------------------------------------------
    // Timebase select codes and divider ratios
    // ------------------------------------------------------------------
    localparam logic [2:0] TB_DIV12   = 3'h0;
    localparam logic [2:0] TB_DIV4    = 3'h1;
    localparam logic [2:0] TB_TIMER0  = 3'h2;
    localparam logic [2:0] TB_EXT_IN  = 3'h3;
    localparam logic [2:0] TB_SYSTEM_CLOCK  = 3'h4;
    localparam logic [2:0] TB_EXT_CLK = 3'h5;
    localparam logic [3:0] DIV12_LAST = 4'hb;
    localparam logic [1:0] DIV4_LAST  = 2'h3;
    localparam logic [2:0] EXT8_LAST  = 3'h7;
    localparam logic [15:0] COUNTER_ALL_ONES = 16'hffff;
    localparam logic [7:0]  LOW_ALL_ONES     = 8'hff;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       write;
    } cawd_sfr_req_s;

    typedef struct packed {
        logic       idle_suspend;
        logic       watchdog_enable_bit;
        logic       watchdog_lock_bit;
        logic [2:0] timebase_select;
        logic       overflow_interrupt_enable;
    } cawd_mode_s;

endpackage

/* File: cawd_timebase.sv */
`timescale 1ns/10ps
module cawd_timebase
    import cawd_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic [2:0] timebase_select,
    input  wire logic       timer0_overflow,
    input  wire logic       external_count_input,
    input  wire logic       external_clock,
    output logic            tick
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] eci_sync_q;
    logic [1:0] ext_sync_q;
    logic       eci_last_q;
    logic       ext_last_q;

    always_ff @(posedge clock) begin
        if (reset) begin
            eci_sync_q <= 2'h3;
            ext_sync_q <= 2'h0;
            eci_last_q <= 1'b1;
            ext_last_q <= 1'b0;
        end else begin
            eci_sync_q <= {eci_sync_q[0], external_count_input};
            ext_sync_q <= {ext_sync_q[0], external_clock};
            eci_last_q <= eci_sync_q[1];
            ext_last_q <= ext_sync_q[1];
        end
    end

    logic eci_fall;
    logic ext_rise;
    assign eci_fall = eci_last_q & ~eci_sync_q[1];
    assign ext_rise = ~ext_last_q & ext_sync_q[1];

    // ------------------------------------------------------------------
    // Prescalers
    // ------------------------------------------------------------------
    logic [3:0] div12_q;
    logic [1:0] div4_q;
    logic [2:0] ext8_q;

    always_ff @(posedge clock) begin
        if (reset) begin
            div12_q <= 4'h0;
            div4_q  <= 2'h0;
            ext8_q  <= 3'h0;
        end else begin
            div12_q <= (div12_q == DIV12_LAST) ? 4'h0 : div12_q + 4'h1;
            div4_q  <= div4_q + 2'h1;
            if (ext_rise)
                ext8_q <= ext8_q + 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // Source select, registered so the counter sees a clean pulse
    // ------------------------------------------------------------------
    logic tick_d;
    always_comb begin
        unique case (timebase_select)
            TB_DIV12:   tick_d = (div12_q == DIV12_LAST);
            TB_DIV4:    tick_d = (div4_q == DIV4_LAST);
            TB_TIMER0:  tick_d = timer0_overflow;
            TB_EXT_IN:  tick_d = eci_fall;
            TB_SYSTEM_CLOCK:  tick_d = 1'b1;
            TB_EXT_CLK: tick_d = ext_rise & (ext8_q == EXT8_LAST);
            default:    tick_d = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset)
            tick <= 1'b0;
        else
            tick <= tick_d;
    end

endmodule // cawd_timebase

/* File: cawd_top.sv */
// Operation
// - Reset on low overflow with update match while active
// - Writing one to module five flag resets while active
// - Timebase and idle select frozen while active
// - Watchdog active when enable or lock set
// - Lock holds watchdog until reset
// - Reset state gives 256 tick timeout
// - Counter wrap sets sticky overflow flag
// - Overflow request gated by interrupt enable
// - Run bit starts and stops counter
// - Module events set sticky flags, interrupt
// - Idle suspend bit pauses array in idle
// - Three bit timebase source decode
// - Enable bit set freezes other mode bits
// - Mode bit four reads zero, ignores writes
// - External input counts falling edges, limited rate
// - Update write loads high plus offset while active, else the written data
// - Watchdog forces run, blocks counter writes
// - Run bit reads software value only
`timescale 1ns/10ps
module cawd_top
    import cawd_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   reset,
    input  wire logic [7:0]             sfr_addr,
    input  wire logic [7:0]             sfr_wdata,
    input  wire logic                   sfr_write,
    output logic      [7:0]             sfr_rdata,
    input  wire logic                   cpu_idle,
    input  wire logic                   timer0_overflow,
    input  wire logic                   external_count_input,
    input  wire logic                   external_clock,
    input  wire logic [NUM_MODULES-1:0] module_events,
    input  wire logic [NUM_MODULES-1:0] module_irq_enable,
    output logic      [15:0]            counter_value,
    output logic                        counter_tick,
    output logic                        watchdog_active,
    output logic                        watchdog_reset,
    output logic                        array_irq
);

    // ------------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------------
    cawd_sfr_req_s req;
    assign req = '{addr: sfr_addr, wdata: sfr_wdata, write: sfr_write};

    logic wr_ctrl;
    logic wr_mode;
    logic wr_low;
    logic wr_high;
    logic wr_offset;
    logic wr_update;

    assign wr_ctrl   = req.write & (req.addr == ADDR_CONTROL_FLAGS);
    assign wr_mode   = req.write & (req.addr == ADDR_MODE);
    assign wr_low    = req.write & (req.addr == ADDR_COUNTER_LOW);
    assign wr_high   = req.write & (req.addr == ADDR_COUNTER_HIGH);
    assign wr_offset = req.write & (req.addr == ADDR_WD_OFFSET);
    assign wr_update = req.write & (req.addr == ADDR_WD_UPDATE);

    // ------------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------------
    cawd_mode_s mode_q;
    logic       active;

    // Lock alone keeps the dog alive even if the enable bit is cleared
    assign active = mode_q.watchdog_enable_bit
                  | mode_q.watchdog_lock_bit;

    always_ff @(posedge clock) begin
        if (reset) begin
            mode_q.idle_suspend              <= MODE_RESET[MODE_IDLE_BIT];
            mode_q.watchdog_enable_bit       <= MODE_RESET[MODE_WDE_BIT];
            mode_q.watchdog_lock_bit         <= MODE_RESET[MODE_LOCK_BIT];
            mode_q.timebase_select           <=
                MODE_RESET[MODE_TB_LSB +: 3];
            mode_q.overflow_interrupt_enable <= MODE_RESET[MODE_OVFI_BIT];
        end else if (wr_mode) begin
            mode_q.watchdog_enable_bit <= req.wdata[MODE_WDE_BIT];
            if (!mode_q.watchdog_enable_bit) begin
                // Lock can only be set; clearing it needs a reset
                if (req.wdata[MODE_LOCK_BIT])
                    mode_q.watchdog_lock_bit <= 1'b1;
                mode_q.overflow_interrupt_enable <=
                    req.wdata[MODE_OVFI_BIT];
                if (!active) begin
                    mode_q.idle_suspend    <= req.wdata[MODE_IDLE_BIT];
                    mode_q.timebase_select <= req.wdata[MODE_TB_LSB +: 3];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Timebase
    // ------------------------------------------------------------------
    logic tick;

    cawd_timebase u_timebase (
        .clock                (clock),
        .reset                (reset),
        .timebase_select      (mode_q.timebase_select),
        .timer0_overflow      (timer0_overflow),
        .external_count_input (external_count_input),
        .external_clock       (external_clock),
        .tick                 (tick)
    );

    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    logic run_q;
    logic suspended;
    logic advance;

    always_ff @(posedge clock) begin
        if (reset)
            run_q <= CONTROL_RESET[CTRL_RUN_BIT];
        else if (wr_ctrl)
            run_q <= req.wdata[CTRL_RUN_BIT];
    end

    assign suspended = mode_q.idle_suspend & cpu_idle;
    // Active watchdog overrides a cleared run bit
    assign advance = tick & (run_q | active) & ~suspended;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    logic [15:0] counter_q;
    logic        wrap;
    logic        low_overflow;

    assign wrap         = advance & (counter_q == COUNTER_ALL_ONES);
    assign low_overflow = advance & (counter_q[7:0] == LOW_ALL_ONES);

    always_ff @(posedge clock) begin
        if (reset) begin
            counter_q <= COUNTER_RESET;
        end else if (wr_low && !active) begin
            counter_q[7:0] <= req.wdata;
        end else if (wr_high && !active) begin
            counter_q[15:8] <= req.wdata;
        end else if (advance) begin
            counter_q <= counter_q + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog compare bytes
    // ------------------------------------------------------------------
    logic [7:0] offset_q;
    logic [7:0] update_q;

    always_ff @(posedge clock) begin
        if (reset)
            offset_q <= BYTE_RESET;
        else if (wr_offset)
            offset_q <= req.wdata;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            update_q <= BYTE_RESET;
        end else if (wr_update) begin
            // Data is ignored while armed; the reload is what counts
            if (active)
                update_q <= counter_q[15:8] + offset_q;
            else
                update_q <= req.wdata;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog reset
    // ------------------------------------------------------------------
    logic timeout;
    logic forced;

    assign timeout = active & low_overflow
                   & (update_q == counter_q[15:8]);
    assign forced  = active & wr_ctrl
                   & req.wdata[CTRL_FIVE_BIT];

    always_ff @(posedge clock) begin
        if (reset)
            watchdog_reset <= 1'b0;
        else
            watchdog_reset <= timeout | forced;
    end

    // ------------------------------------------------------------------
    // Sticky flags: hardware set wins over software clear
    // ------------------------------------------------------------------
    logic                   ovf_flag_q;
    logic [NUM_MODULES-1:0] match_flags_q;

    always_ff @(posedge clock) begin
        if (reset)
            ovf_flag_q <= CONTROL_RESET[CTRL_OVF_BIT];
        else if (wrap)
            ovf_flag_q <= 1'b1;
        else if (wr_ctrl)
            ovf_flag_q <= req.wdata[CTRL_OVF_BIT];
    end

    genvar m;
    generate
        for (m = 0; m < NUM_MODULES; m++) begin : g_flag
            always_ff @(posedge clock) begin
                if (reset)
                    match_flags_q[m] <= CONTROL_RESET[m];
                else if (module_events[m])
                    match_flags_q[m] <= 1'b1;
                else if (wr_ctrl)
                    match_flags_q[m] <= req.wdata[m];
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset)
            array_irq <= 1'b0;
        else
            array_irq <= (ovf_flag_q
                          & mode_q.overflow_interrupt_enable)
                       | (|(match_flags_q & module_irq_enable));
    end

    // ------------------------------------------------------------------
    // Read path, one cycle behind the address
    // ------------------------------------------------------------------
    logic [7:0] rdata_d;
    logic [7:0] mode_read;

    always_comb begin
        mode_read = 8'h00;
        mode_read[MODE_IDLE_BIT]     = mode_q.idle_suspend;
        mode_read[MODE_WDE_BIT]      = mode_q.watchdog_enable_bit;
        mode_read[MODE_LOCK_BIT]     = mode_q.watchdog_lock_bit;
        mode_read[MODE_TB_LSB +: 3]  = mode_q.timebase_select;
        mode_read[MODE_OVFI_BIT]     = mode_q.overflow_interrupt_enable;
    end

    always_comb begin
        rdata_d = 8'h00;
        if (req.addr == ADDR_CONTROL_FLAGS) begin
            rdata_d[CTRL_OVF_BIT]         = ovf_flag_q;
            rdata_d[CTRL_RUN_BIT]         = run_q;
            rdata_d[NUM_MODULES-1:0]      = match_flags_q;
        end else if (req.addr == ADDR_MODE) begin
            rdata_d = mode_read;
        end else if (req.addr == ADDR_COUNTER_LOW) begin
            rdata_d = counter_q[7:0];
        end else if (req.addr == ADDR_COUNTER_HIGH) begin
            rdata_d = counter_q[15:8];
        end else if (req.addr == ADDR_WD_OFFSET) begin
            rdata_d = offset_q;
        end else if (req.addr == ADDR_WD_UPDATE) begin
            rdata_d = update_q;
        end
    end

    always_ff @(posedge clock) begin
        if (reset)
            sfr_rdata <= 8'h00;
        else
            sfr_rdata <= rdata_d;
    end

    // ------------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            counter_value   <= COUNTER_RESET;
            counter_tick    <= 1'b0;
            watchdog_active <= 1'b1;
        end else begin
            counter_value   <= counter_q;
            counter_tick    <= advance;
            watchdog_active <= active;
        end
    end

endmodule // cawd_top

/* File: cawd_top_monitor.sv */
`timescale 1ns/10ps
module cawd_top_monitor
    import cawd_pkg::*;
(
    input wire logic                   clock,
    input wire logic                   reset,
    input wire logic [7:0]             sfr_addr,
    input wire logic [7:0]             sfr_wdata,
    input wire logic                   sfr_write,
    input wire logic [7:0]             sfr_rdata,
    input wire logic                   cpu_idle,
    input wire logic                   timer0_overflow,
    input wire logic                   external_count_input,
    input wire logic                   external_clock,
    input wire logic [NUM_MODULES-1:0] module_events,
    input wire logic [NUM_MODULES-1:0] module_irq_enable,
    input wire logic [15:0]            counter_value,
    input wire logic                   counter_tick,
    input wire logic                   watchdog_active,
    input wire logic                   watchdog_reset,
    input wire logic                   array_irq
);
    // ------------------------------------------------------------------
    // Decoded register traffic
    // ------------------------------------------------------------------
    logic mode_wr;
    logic five_wr;
    logic mapped;
    assign mode_wr = sfr_write && (sfr_addr == ADDR_MODE);
    assign five_wr = sfr_write && (sfr_addr == ADDR_CONTROL_FLAGS)
                     && sfr_wdata[CTRL_FIVE_BIT];
    assign mapped  = sfr_addr inside {ADDR_CONTROL_FLAGS, ADDR_MODE,
                     ADDR_COUNTER_LOW, ADDR_COUNTER_HIGH, ADDR_WD_OFFSET,
                     ADDR_WD_UPDATE};

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    reset_state_a: assert property (
        @(posedge clock) reset |=> watchdog_active && !watchdog_reset
        && !array_irq && (sfr_rdata == 8'h00))
        else $error("reset state wrong");
    forced_reset_a: assert property (
        @(posedge clock) disable iff (reset)
        five_wr && watchdog_active |-> ##[1:2] watchdog_reset)
        else $error("forced watchdog reset missing");
    reset_pulse_a: assert property (
        @(posedge clock) disable iff (reset)
        watchdog_reset |=> !watchdog_reset)
        else $error("watchdog reset longer than one cycle");
    reset_needs_active_a: assert property (
        @(posedge clock) disable iff (reset)
        watchdog_reset |-> $past(watchdog_active))
        else $error("watchdog reset while inactive");
    stays_off_a: assert property (
        @(posedge clock) disable iff (reset)
        !watchdog_active && !mode_wr && !$past(mode_wr) |=> !watchdog_active)
        else $error("watchdog enabled without mode write");
    stays_on_a: assert property (
        @(posedge clock) disable iff (reset)
        watchdog_active && !mode_wr && !$past(mode_wr) |=> watchdog_active)
        else $error("watchdog dropped without mode write");
    event_irq_a: assert property (
        @(posedge clock) disable iff (reset)
        |(module_events & module_irq_enable) |-> ##[1:3] array_irq)
        else $error("module event raised no interrupt");
    unmapped_zero_a: assert property (
        @(posedge clock) disable iff (reset)
        !mapped |=> sfr_rdata == 8'h00)
        else $error("unmapped address read nonzero");
    mode_bit_four_a: assert property (
        @(posedge clock) disable iff (reset)
        sfr_addr == ADDR_MODE |=> !sfr_rdata[4])
        else $error("mode bit four read as one");

    cover property (@(posedge clock) watchdog_reset);
    cover property (@(posedge clock) array_irq);
    cover property (@(posedge clock) counter_tick && !watchdog_active);
endmodule // cawd_top_monitor

/* File: tb_array_watchdog_and_counter_control.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_array_watchdog_and_counter_control
    import cawd_pkg::*;
;
    logic                   clock, reset, sfr_write, cpu_idle;
    logic                   timer0_overflow, external_count_input;
    logic                   external_clock, counter_tick, array_irq;
    logic                   watchdog_active, watchdog_reset;
    logic [7:0]             sfr_addr, sfr_wdata, sfr_rdata, rd_val;
    logic [NUM_MODULES-1:0] module_events, module_irq_enable;
    logic [15:0]            counter_value, c0;
    int                     error_cnt = 0, check_count = 0, cyc = 0;
    int                     ticks = 0, pulses = 0, gen = 0, t0, d, p;
    int                     tb_exp [8] = '{8, 24, 12, 12, 96, 6, 0, 0};

    cawd_top dut (.clock(clock), .reset(reset), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_write(sfr_write), .sfr_rdata(sfr_rdata),
        .cpu_idle(cpu_idle), .timer0_overflow(timer0_overflow),
        .external_count_input(external_count_input),
        .external_clock(external_clock), .module_events(module_events),
        .module_irq_enable(module_irq_enable),
        .counter_value(counter_value), .counter_tick(counter_tick),
        .watchdog_active(watchdog_active),
        .watchdog_reset(watchdog_reset), .array_irq(array_irq));

    // ------------------------------------------------------------------
    // Clock, timeout and event counting
    // ------------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (counter_tick === 1'b1) ticks++;
        if (watchdog_reset === 1'b1) pulses++;
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end
    // Timer 0 and ext input every 8 cycles, ext clock rising edge every 2
    always @(negedge clock) begin
        gen <= gen + 1;
        timer0_overflow <= (gen % 8 == 0);
        external_count_input <= gen[2];
        external_clock <= gen[0];
    end

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task results();
        if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task cyc_wait(input int n);
        repeat (n) @(negedge clock);
    endtask
    task do_reset();
        @(negedge clock) reset = 1'b1;
        repeat (20) @(negedge clock);
        reset = 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clock);
        sfr_addr = a;
        sfr_wdata = v;
        sfr_write = 1'b1;
        @(negedge clock);
        sfr_write = 1'b0;
    endtask
    // Read data is registered, so it is taken one edge after the address
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clock) sfr_addr = a;
        @(negedge clock) v = sfr_rdata;
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        {reset, sfr_addr, sfr_wdata, sfr_write, cpu_idle} = '0;
        {timer0_overflow, external_clock, module_events} = '0;
        {reset, external_count_input, module_irq_enable} = 8'hff;
        do_reset();
        t0 = cyc;
        rd(ADDR_CONTROL_FLAGS, rd_val); `CHK(rd_val, CONTROL_RESET)
        rd(ADDR_MODE, rd_val); `CHK(rd_val, MODE_RESET)
        `CHK(watchdog_active, 1'b1)
        rd(8'h00, rd_val); `CHK(rd_val, 8'h00)
        p = pulses;
        while (pulses == p && cyc - t0 < 4000) @(negedge clock);
        `CHK((cyc - t0) inside {[3065:3085]}, 1'b1)
        wr(ADDR_MODE, 8'h00); cyc_wait(3);
        `CHK(watchdog_active, 1'b0)
        p = pulses; wr(ADDR_CONTROL_FLAGS, 8'h20); cyc_wait(3);
        `CHK(pulses, p)
        wr(ADDR_CONTROL_FLAGS, 8'h00);
        wr(ADDR_MODE, 8'h10); rd(ADDR_MODE, rd_val);
        `CHK(rd_val, 8'h00)
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_MODE, {4'h0, i[2:0], 1'b0});
            wr(ADDR_CONTROL_FLAGS, 8'h40);
            cyc_wait(4); t0 = ticks; cyc_wait(96); d = ticks - t0;
            p = (tb_exp[i] == 0) ? (d == 0)
                : ((d - tb_exp[i]) inside {[-2:2]});
            `CHK(p, 1)
        end
        wr(ADDR_CONTROL_FLAGS, 8'h00); wr(ADDR_MODE, 8'h08);
        wr(ADDR_COUNTER_HIGH, 8'hff); wr(ADDR_COUNTER_LOW, 8'hf0);
        wr(ADDR_CONTROL_FLAGS, 8'h40); cyc_wait(40);
        rd(ADDR_CONTROL_FLAGS, rd_val); `CHK(rd_val[7:6], 2'h3)
        wr(ADDR_MODE, 8'h09); cyc_wait(3); `CHK(array_irq, 1'b1)
        wr(ADDR_MODE, 8'h08); cyc_wait(3); `CHK(array_irq, 1'b0)
        wr(ADDR_MODE, 8'h09); wr(ADDR_CONTROL_FLAGS, 8'h00); cyc_wait(3);
        `CHK(array_irq, 1'b0)
        rd(ADDR_CONTROL_FLAGS, rd_val); `CHK(rd_val, 8'h00)
        c0 = counter_value; cyc_wait(10); `CHK(counter_value, c0)
        wr(ADDR_MODE, 8'h88); wr(ADDR_CONTROL_FLAGS, 8'h40); cpu_idle = 1'b1;
        cyc_wait(3); c0 = counter_value; cyc_wait(10);
        `CHK(counter_value, c0)
        cpu_idle = 1'b0; cyc_wait(10);
        `CHK(counter_value != c0, 1'b1)
        wr(ADDR_MODE, 8'h08); cpu_idle = 1'b1; c0 = counter_value;
        cyc_wait(10); `CHK(counter_value != c0, 1'b1)
        cpu_idle = 1'b0; wr(ADDR_CONTROL_FLAGS, 8'h00);
        for (int n = 0; n < NUM_MODULES; n++) begin
            module_events = 6'h01 << n; @(negedge clock); module_events = '0;
            cyc_wait(3); `CHK(array_irq, 1'b1)
            rd(ADDR_CONTROL_FLAGS, rd_val); `CHK(rd_val, 8'h01 << n)
            wr(ADDR_CONTROL_FLAGS, 8'h00); cyc_wait(3);
            `CHK(array_irq, 1'b0)
        end
        module_irq_enable = 6'h3b; module_events = 6'h04; @(negedge clock);
        module_events = '0; cyc_wait(3); `CHK(array_irq, 1'b0)
        wr(ADDR_CONTROL_FLAGS, 8'h00); module_irq_enable = 6'h3f;
        wr(ADDR_WD_OFFSET, 8'h05); wr(ADDR_COUNTER_HIGH, 8'h10);
        wr(ADDR_COUNTER_LOW, 8'h00); wr(ADDR_MODE, 8'h00);
        wr(ADDR_MODE, 8'h40); cyc_wait(3);
        `CHK(watchdog_active, 1'b1)
        wr(ADDR_MODE, 8'h41); rd(ADDR_MODE, rd_val);
        `CHK(rd_val, 8'h40)
        wr(ADDR_WD_UPDATE, 8'h77); rd(ADDR_WD_UPDATE, rd_val);
        `CHK(rd_val, 8'h15)
        rd(ADDR_CONTROL_FLAGS, rd_val); `CHK(rd_val, 8'h00)
        c0 = counter_value; wr(ADDR_CONTROL_FLAGS, 8'h00); cyc_wait(30);
        `CHK(counter_value != c0, 1'b1)
        wr(ADDR_COUNTER_LOW, 8'haa); rd(ADDR_COUNTER_LOW, rd_val);
        `CHK(rd_val < 8'h40, 1'b1)
        wr(ADDR_MODE, 8'h00); cyc_wait(3);
        `CHK(watchdog_active, 1'b0)
        wr(ADDR_MODE, 8'h20); cyc_wait(3);
        `CHK(watchdog_active, 1'b1)
        wr(ADDR_MODE, 8'h00); wr(ADDR_MODE, 8'h28); cyc_wait(3);
        `CHK(watchdog_active, 1'b1)
        rd(ADDR_MODE, rd_val); `CHK(rd_val, 8'h20)
        p = pulses; wr(ADDR_CONTROL_FLAGS, 8'h20); cyc_wait(3);
        `CHK(pulses, p + 1)
        do_reset(); cyc_wait(2); `CHK(watchdog_active, 1'b1)
        rd(ADDR_MODE, rd_val); `CHK(rd_val, MODE_RESET)
        results();
    end
endmodule // tb_array_watchdog_and_counter_control

bind cawd_top cawd_top_monitor u_mon (.clock(clock), .reset(reset),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_write(sfr_write),
    .sfr_rdata(sfr_rdata), .cpu_idle(cpu_idle),
    .timer0_overflow(timer0_overflow),
    .external_count_input(external_count_input),
    .external_clock(external_clock), .module_events(module_events),
    .module_irq_enable(module_irq_enable), .counter_value(counter_value),
    .counter_tick(counter_tick), .watchdog_active(watchdog_active),
    .watchdog_reset(watchdog_reset), .array_irq(array_irq));
